// *** pkg/dpr_link_if.sv ***
// Command, address, clock-enable and clock-run pins between the ends.
// Assumes the bench joins the two modports; ck_run low means clock held.
interface dpr_link_if;
  import dpr_pkg::*;
  logic              ck_run;
  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [ADDR_W-1:0] addr;
  logic [BANK_W-1:0] ba;
  modport ctrl (output ck_run, cke, cs_n, ras_n, cas_n, we_n, addr, ba);
  modport dev  (input  ck_run, cke, cs_n, ras_n, cas_n, we_n, addr, ba);
endinterface

// *** pkg/dpr_pkg.sv ***
// Shared constants and types for the precharge, refresh and power state
// link between the memory controller end and the memory device end.
// Assumes both ends run from one 100 MHz core clock.
package dpr_pkg;
  localparam int CLK_MHZ      = 100;
  localparam int BANKS        = 4;
  localparam int BANK_W       = 2;
  localparam int ADDR_W       = 13;
  localparam int ROW_W        = 12;
  localparam int TMR_W        = 8;
  localparam int DW_W         = 16;
  localparam int PRE_ALL_BIT  = 10;
  localparam int MAX_POSTPONE = 8;
  localparam int BURST_LEN    = 4;
  localparam int CAS_LAT      = 3;
  localparam int BURST_CYC    = BURST_LEN / 2;

  localparam logic [BANK_W-1:0] MR_BASE_BANK = 2'h0;
  localparam logic [BANK_W-1:0] MR_EXT_BANK  = 2'h2;

  // Command encoding on {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // Times in their own units
  localparam int T_RP_NS   = 18;
  localparam int T_RCD_NS  = 18;
  localparam int T_WR_NS   = 15;
  localparam int T_MRD_NS  = 20;
  localparam int T_RFC_NS  = 72;
  localparam int T_XSR_NS  = 120;
  localparam int T_XP_NS   = 10;
  localparam int T_CKE_NS  = 20;
  localparam int T_REFW_MS = 64;
  localparam int REF_ROWS  = 4096;
  localparam int T_DEEP_US = 200;

  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RP_CYC   = cyc_min(T_RP_NS);
  localparam int RCD_CYC  = cyc_min(T_RCD_NS);
  localparam int WR_CYC   = cyc_min(T_WR_NS);
  localparam int MRD_CYC  = cyc_min(T_MRD_NS);
  localparam int RFC_CYC  = cyc_min(T_RFC_NS);
  localparam int XSR_CYC  = cyc_min(T_XSR_NS);
  localparam int XP_CYC   = cyc_min(T_XP_NS);
  localparam int CKE_CYC  = cyc_min(T_CKE_NS);
  localparam int REFI_CYC = (T_REFW_MS * 1000000 / REF_ROWS) * CLK_MHZ / 1000;
  localparam int DEEP_CYC = T_DEEP_US * CLK_MHZ;

  typedef enum logic [2:0] {
    MD_RUN, MD_PRE_PDN, MD_ACT_PDN, MD_SREF, MD_DEEP_PDN, MD_UNINIT, MD_CKSTOP
  } dpr_mode_t;

  typedef enum logic [3:0] {
    OP_ACT, OP_RD, OP_WR, OP_PRE, OP_PRE_ALL, OP_REF,
    OP_SREF, OP_PDN, OP_DEEP_PDN, OP_CKSTOP, OP_WAKE
  } dpr_op_t;
endpackage

// *** rtl/dpr_mem_ctrl.sv ***
// Memory controller end: issues commands, tracks banks and timers,
// schedules refresh and drives the low-power states and clock stop.
// Assumes one user request at a time, held until ack or reject.
// Function
// - Precharge closes rows; activate waits row precharge
// - Address bit 10 picks all banks
// - Read or write only to activated bank
// - Device ignores precharge of idle bank
// - Address bit 10 on access auto-precharges
// - Wait precharge time after auto precharge
// - Refresh every row within 64 ms
// - One refresh per auto refresh command
// - Self refresh: refresh code, clock-enable low
// - Stay in self refresh refresh cycle time
// - Clock stable before exit, then wait
// - Extra auto refresh after self refresh
// - Clock-enable low idle enters power-down
// - Hold power-down minimum clock-enable time
// - Exit power-down with nop, then wait
// - Deep power-down: terminate code, banks idle
// - Deep power-down loses data; hold low
// - Deep exit: 200 us nops, reinitialise
// - Stop clock only after all timings
// - Clock stop from idle or active
// - Nop after clock restart before access
module dpr_mem_ctrl #(
  parameter int                  DEEP_WAIT_CYC = dpr_pkg::DEEP_CYC,
  parameter int                  REFI_CYC      = dpr_pkg::REFI_CYC,
  parameter logic [12:0]         MODE_WORD     = 13'h0000,
  parameter logic [12:0]         EXT_MODE_WORD = 13'h0000
) (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_sys_rst,
  dpr_link_if.ctrl                         link,
  input  wire logic                        i_cmd_valid,
  input  wire dpr_pkg::dpr_op_t            i_cmd_op,
  input  wire logic [dpr_pkg::BANK_W-1:0]  i_cmd_bank,
  input  wire logic [dpr_pkg::ADDR_W-1:0]  i_cmd_addr,
  input  wire logic                        i_cmd_auto_pre,
  output logic                             o_cmd_ack,
  output logic                             o_cmd_reject,
  output dpr_pkg::dpr_mode_t               o_dev_mode,
  output logic [3:0]                       o_ref_pending
);
  import dpr_pkg::*;

  dpr_mode_t          st_reg, st_next;
  logic [2:0]         cmd_reg, cmd_next;
  logic [ADDR_W-1:0]  addr_reg, addr_next;
  logic [BANK_W-1:0]  ba_reg, ba_next;
  logic               cke_reg, cke_next;
  logic               run_reg, run_next;
  logic [TMR_W-1:0]   gap_reg, gap_next;
  logic [DW_W-1:0]    dwell_reg, dwell_next;
  logic [2:0]         step_reg, step_next;
  logic               ack_reg, ack_next;
  logic               rej_reg, rej_next;
  logic [DW_W-1:0]    refi_reg;
  logic [3:0]         pend_reg;
  logic               open_reg [BANKS];
  logic [TMR_W-1:0]   btmr_reg [BANKS];
  logic [BANKS-1:0]   open_vec;
  logic [BANKS-1:0]   busy_vec;
  logic [BANKS-1:0]   set_m, clr_m, ld_m;
  logic [TMR_W-1:0]   ld_v;
  logic               ref_iss, pend_one, pend_zero;

  wire [BANKS-1:0] one_m   = BANKS'(1) << i_cmd_bank;
  wire       usr       = i_cmd_valid & ~ack_reg & ~rej_reg;
  wire       wake      = usr & (i_cmd_op == OP_WAKE);
  wire       can_cmd   = (gap_reg == '0) & ~ack_reg & ~rej_reg;
  wire       all_closed = ~|open_vec;
  wire       tmr_clear = ~|busy_vec;
  wire       tgt_open  = open_reg[i_cmd_bank];
  wire       tgt_ready = btmr_reg[i_cmd_bank] == '0;
  wire       ref_due   = pend_reg != 4'h0;
  wire       ref_force = pend_reg == 4'(MAX_POSTPONE);
  wire       ref_count = (st_reg == MD_RUN) | (st_reg == MD_PRE_PDN)
                         | (st_reg == MD_ACT_PDN) | (st_reg == MD_CKSTOP);
  wire       tick      = ref_count & (refi_reg == '0);
  wire       pend_inc  = tick & ~ref_force;
  wire [TMR_W-1:0] rw_gap = TMR_W'(BURST_CYC + CAS_LAT);
  wire [TMR_W-1:0] wr_rec = TMR_W'(1 + BURST_CYC + WR_CYC);
  wire [TMR_W-1:0] ap_rp  = TMR_W'(BURST_CYC + RP_CYC);

  always_comb begin
    st_next = st_reg;
    cmd_next = CMD_NOP;
    addr_next = '0;
    ba_next = '0;
    cke_next = cke_reg;
    run_next = run_reg;
    gap_next = (gap_reg == '0) ? gap_reg : gap_reg - 1'b1;
    dwell_next = (dwell_reg == '0) ? dwell_reg : dwell_reg - 1'b1;
    step_next = step_reg;
    ack_next = 1'b0;
    rej_next = 1'b0;
    set_m = '0;
    clr_m = '0;
    ld_m = '0;
    ld_v = '0;
    ref_iss = 1'b0;
    pend_one = 1'b0;
    pend_zero = 1'b0;
    case (st_reg)
      MD_RUN: begin
        if (can_cmd & (ref_force | (ref_due & ~usr))) begin
          if (tmr_clear & ~all_closed) begin
            cmd_next = CMD_PRE; // close rows for forced refresh or due refresh with no request
            addr_next[PRE_ALL_BIT] = 1'b1;
            clr_m = open_vec;
            ld_m = open_vec;
            ld_v = TMR_W'(RP_CYC);
            gap_next = TMR_W'(1);
          end else if (tmr_clear) begin
            cmd_next = CMD_REF;
            ref_iss = 1'b1;
            gap_next = TMR_W'(RFC_CYC);
          end
        end else if (can_cmd & usr) begin
          case (i_cmd_op)
            OP_ACT: begin
              if (tgt_open)
                rej_next = 1'b1;
              else if (tgt_ready) begin
                cmd_next = CMD_ACT;
                ba_next = i_cmd_bank;
                addr_next = i_cmd_addr;
                set_m = one_m;
                ld_m = one_m;
                ld_v = TMR_W'(RCD_CYC);
                gap_next = TMR_W'(1);
                ack_next = 1'b1;
              end
            end
            OP_RD, OP_WR: begin
              if (!tgt_open)
                rej_next = 1'b1;
              else if (tgt_ready) begin
                cmd_next = (i_cmd_op == OP_RD) ? CMD_RD : CMD_WR;
                ba_next = i_cmd_bank;
                addr_next = i_cmd_addr;
                addr_next[PRE_ALL_BIT] = i_cmd_auto_pre;
                gap_next = rw_gap;
                ack_next = 1'b1;
                if (i_cmd_op == OP_WR) begin
                  ld_m = one_m;
                  ld_v = i_cmd_auto_pre ? wr_rec + TMR_W'(RP_CYC) : wr_rec;
                end else if (i_cmd_auto_pre) begin
                  ld_m = one_m;
                  ld_v = ap_rp;
                end
                if (i_cmd_auto_pre)
                  clr_m = one_m;
              end
            end
            OP_PRE, OP_PRE_ALL: begin
              if ((i_cmd_op == OP_PRE) ? tgt_ready : tmr_clear) begin
                cmd_next = CMD_PRE;
                ba_next = i_cmd_bank;
                addr_next[PRE_ALL_BIT] = i_cmd_op == OP_PRE_ALL;
                clr_m = (i_cmd_op == OP_PRE) ? one_m & open_vec : open_vec;
                ld_m = clr_m;
                ld_v = TMR_W'(RP_CYC);
                gap_next = TMR_W'(1);
                ack_next = 1'b1;
              end
            end
            OP_REF, OP_SREF, OP_DEEP_PDN: begin
              if (!all_closed)
                rej_next = 1'b1;
              else if (tmr_clear) begin
                ack_next = 1'b1;
                cmd_next = (i_cmd_op == OP_DEEP_PDN) ? CMD_BST : CMD_REF;
                gap_next = TMR_W'(RFC_CYC);
                if (i_cmd_op == OP_REF)
                  ref_iss = 1'b1;
                else begin
                  cke_next = 1'b0;
                  pend_zero = 1'b1;
                  gap_next = TMR_W'(1);
                  st_next = (i_cmd_op == OP_DEEP_PDN) ? MD_DEEP_PDN : MD_SREF;
                  dwell_next = DW_W'(RFC_CYC);
                end
              end
            end
            OP_PDN: begin
              if (tmr_clear) begin
                cke_next = 1'b0;
                st_next = all_closed ? MD_PRE_PDN : MD_ACT_PDN;
                dwell_next = DW_W'(CKE_CYC);
                ack_next = 1'b1;
              end
            end
            OP_CKSTOP: begin
              if (tmr_clear) begin
                run_next = 1'b0;
                st_next = MD_CKSTOP;
                ack_next = 1'b1;
              end
            end
            default: ack_next = 1'b1;
          endcase
        end
      end
      MD_PRE_PDN, MD_ACT_PDN: begin
        if ((dwell_reg == '0) & (wake | ref_force)) begin
          cke_next = 1'b1;
          st_next = MD_RUN;
          gap_next = TMR_W'(XP_CYC);
          ack_next = wake;
        end else if (usr & ~wake)
          rej_next = 1'b1;
      end
      MD_SREF: begin
        if ((dwell_reg == '0) & wake & run_reg) begin
          cke_next = 1'b1;
          st_next = MD_RUN;
          gap_next = TMR_W'(XSR_CYC);
          pend_one = 1'b1;
          ack_next = 1'b1;
        end else if ((dwell_reg == '0) & wake)
          run_next = 1'b1;
        else if (usr & ~wake)
          rej_next = 1'b1;
        else
          run_next = 1'b0;
      end
      MD_DEEP_PDN: begin
        if (wake) begin
          cke_next = 1'b1;
          st_next = MD_UNINIT;
          dwell_next = DW_W'(DEEP_WAIT_CYC);
          step_next = 3'h0;
          ack_next = 1'b1;
        end else if (usr)
          rej_next = 1'b1;
      end
      MD_UNINIT: begin
        if ((dwell_reg == '0) & can_cmd) begin
          step_next = step_reg + 1'b1;
          case (step_reg)
            3'h0: begin
              cmd_next = CMD_PRE;
              addr_next[PRE_ALL_BIT] = 1'b1;
              gap_next = TMR_W'(RP_CYC);
            end
            3'h1, 3'h2: begin
              cmd_next = CMD_REF;
              gap_next = TMR_W'(RFC_CYC);
            end
            3'h3: begin
              cmd_next = CMD_MRS;
              addr_next = MODE_WORD;
              ba_next = MR_BASE_BANK;
              gap_next = TMR_W'(MRD_CYC);
            end
            default: begin
              cmd_next = CMD_MRS;
              addr_next = EXT_MODE_WORD;
              ba_next = MR_EXT_BANK;
              gap_next = TMR_W'(MRD_CYC);
              st_next = MD_RUN;
            end
          endcase
        end else if (usr)
          rej_next = 1'b1;
      end
      MD_CKSTOP: begin
        if (wake | ref_due) begin
          run_next = 1'b1;
          st_next = MD_RUN;
          gap_next = TMR_W'(1);
          ack_next = wake;
        end else if (usr)
          rej_next = 1'b1;
      end
      default: st_next = MD_RUN;
    endcase
  end

  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    assign open_vec[b] = open_reg[b];
    assign busy_vec[b] = btmr_reg[b] != '0;
    always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
        open_reg[b] <= 1'b0;
        btmr_reg[b] <= '0;
      end else begin
        if (set_m[b])
          open_reg[b] <= 1'b1;
        else if (clr_m[b])
          open_reg[b] <= 1'b0;
        if (ld_m[b])
          btmr_reg[b] <= ld_v;
        else if (busy_vec[b])
          btmr_reg[b] <= btmr_reg[b] - 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_reg    <= MD_RUN;
      cmd_reg   <= CMD_NOP;
      addr_reg  <= '0;
      ba_reg    <= '0;
      cke_reg   <= 1'b1;
      run_reg   <= 1'b1;
      gap_reg   <= '0;
      dwell_reg <= '0;
      step_reg  <= 3'h0;
      ack_reg   <= 1'b0;
      rej_reg   <= 1'b0;
    end else begin
      st_reg    <= st_next;
      cmd_reg   <= cmd_next;
      addr_reg  <= addr_next;
      ba_reg    <= ba_next;
      cke_reg   <= cke_next;
      run_reg   <= run_next;
      gap_reg   <= gap_next;
      dwell_reg <= dwell_next;
      step_reg  <= step_next;
      ack_reg   <= ack_next;
      rej_reg   <= rej_next;
    end
  end

  // Refresh interval counter; a new tick and a refresh issued in one cycle cancel out, except at MAX_POSTPONE where the tick is dropped
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      refi_reg <= DW_W'(REFI_CYC - 1);
      pend_reg <= 4'h0;
    end else begin
      if (!ref_count | tick)
        refi_reg <= DW_W'(REFI_CYC - 1);
      else
        refi_reg <= refi_reg - 1'b1;
      if (pend_one)
        pend_reg <= 4'h1;
      else if (pend_zero)
        pend_reg <= 4'h0;
      else if (pend_inc & ~ref_iss)
        pend_reg <= pend_reg + 1'b1;
      else if (~pend_inc & ref_iss)
        pend_reg <= pend_reg - 1'b1;
    end
  end

  assign link.cs_n    = 1'b0;
  assign link.ras_n   = cmd_reg[2];
  assign link.cas_n   = cmd_reg[1];
  assign link.we_n    = cmd_reg[0];
  assign link.addr    = addr_reg;
  assign link.ba      = ba_reg;
  assign link.cke     = cke_reg;
  assign link.ck_run  = run_reg;
  assign o_cmd_ack     = ack_reg;
  assign o_cmd_reject  = rej_reg;
  assign o_dev_mode    = st_reg;
  assign o_ref_pending = pend_reg;
endmodule

// *** rtl/dpr_mem_dev.sv ***
// Memory device end: bank precharge, auto precharge, refresh counter and
// power states. Assumes link pins are synchronous to i_core_clk.
module dpr_mem_dev (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_sys_rst,
  dpr_link_if.dev                          link,
  output dpr_pkg::dpr_mode_t               o_mode,
  output logic [dpr_pkg::BANKS-1:0]        o_bank_open,
  output logic [dpr_pkg::ROW_W-1:0]        o_refresh_row,
  output logic                             o_refresh_pulse,
  output logic                             o_pre_ignored,
  output logic                             o_data_lost
);
  import dpr_pkg::*;

  dpr_mode_t          mode_reg, mode_next;
  logic               cke_prev_reg;
  logic               open_reg [BANKS];
  logic [TMR_W-1:0]   rp_reg [BANKS];
  logic [TMR_W-1:0]   ap_reg [BANKS];
  logic [ROW_W-1:0]   row_reg;
  logic [DW_W-1:0]    sr_tmr_reg;
  logic [1:0]         mr_seen_reg;
  logic               ref_pulse_reg;
  logic               ign_reg;
  logic               lost_reg;
  logic [BANKS-1:0]   open_vec;
  logic [BANKS-1:0]   ap_vec;
  logic [BANKS-1:0]   tgt_vec;

  wire [2:0] cmd      = {link.ras_n, link.cas_n, link.we_n};
  wire       is_nop   = link.cs_n | (cmd == CMD_NOP);
  wire       awake    = (mode_reg == MD_RUN) | (mode_reg == MD_UNINIT);
  wire       live     = link.ck_run & awake & cke_prev_reg & link.cke;
  wire       fall     = link.ck_run & awake & cke_prev_reg & ~link.cke;
  wire       rise     = link.ck_run & ~cke_prev_reg & link.cke;
  wire       pre_all  = link.addr[PRE_ALL_BIT];
  wire       c_pre    = live & ~link.cs_n & (cmd == CMD_PRE);
  wire       c_act    = live & ~link.cs_n & (cmd == CMD_ACT);
  wire       c_ref    = live & ~link.cs_n & (cmd == CMD_REF);
  wire       c_mrs    = live & ~link.cs_n & (cmd == CMD_MRS);
  wire       c_rw     = live & ~link.cs_n & (mode_reg == MD_RUN)
                        & ((cmd == CMD_RD) | (cmd == CMD_WR));
  wire       all_idle = ~|open_vec & ~|ap_vec;
  wire       sr_tick  = (mode_reg == MD_SREF) & (sr_tmr_reg == '0);
  wire       deep_in  = fall & ~link.cs_n & (cmd == CMD_BST) & all_idle;
  wire       ign_next = c_pre & ~|(tgt_vec & open_vec);
  wire       ret_mode = lost_reg;

  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    wire hit    = link.ba == BANK_W'(b);
    wire pre_b  = c_pre & tgt_vec[b] & open_reg[b];
    wire ap_end = ap_reg[b] == TMR_W'(1);
    wire ap_go  = c_rw & hit & pre_all & open_reg[b] & (ap_reg[b] == '0);
    assign tgt_vec[b]  = pre_all | hit;
    assign open_vec[b] = open_reg[b];
    assign ap_vec[b]   = ap_reg[b] != '0;
    always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
        open_reg[b] <= 1'b0;
        rp_reg[b]   <= '0;
        ap_reg[b]   <= '0;
      end else begin
        if (c_act & hit & ~open_reg[b] & (rp_reg[b] == '0))
          open_reg[b] <= 1'b1;
        else if (pre_b | ap_end)
          open_reg[b] <= 1'b0;
        if (pre_b | ap_end)
          rp_reg[b] <= TMR_W'(RP_CYC);
        else if (rp_reg[b] != '0)
          rp_reg[b] <= rp_reg[b] - 1'b1;
        if (ap_go)
          ap_reg[b] <= TMR_W'(BURST_CYC);
        else if (ap_reg[b] != '0)
          ap_reg[b] <= ap_reg[b] - 1'b1;
      end
    end
  end

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      MD_RUN, MD_UNINIT: begin
        if (fall & ~link.cs_n & (cmd == CMD_REF) & all_idle)
          mode_next = MD_SREF;
        else if (deep_in)
          mode_next = MD_DEEP_PDN;
        else if (fall & is_nop & ~|ap_vec)
          mode_next = |open_vec ? MD_ACT_PDN : MD_PRE_PDN;
        else if ((mode_reg == MD_UNINIT) & (mr_seen_reg == 2'h3))
          mode_next = MD_RUN;
      end
      MD_PRE_PDN, MD_ACT_PDN: begin
        if (rise & is_nop)
          mode_next = ret_mode ? MD_UNINIT : MD_RUN;
      end
      MD_SREF: begin
        if (rise)
          mode_next = ret_mode ? MD_UNINIT : MD_RUN;
      end
      MD_DEEP_PDN: begin
        if (rise)
          mode_next = MD_UNINIT;
      end
      default: mode_next = MD_RUN;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      mode_reg     <= MD_RUN;
      cke_prev_reg <= 1'b1;
    end else begin
      mode_reg <= mode_next;
      if (link.ck_run)
        cke_prev_reg <= link.cke;
    end
  end

  // Row counter advances on auto refresh or internal self refresh timer
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      row_reg       <= '0;
      sr_tmr_reg    <= DW_W'(REFI_CYC);
      ref_pulse_reg <= 1'b0;
    end else begin
      ref_pulse_reg <= c_ref | sr_tick;
      if (c_ref | sr_tick)
        row_reg <= row_reg + 1'b1;
      if ((mode_reg != MD_SREF) | sr_tick)
        sr_tmr_reg <= DW_W'(REFI_CYC);
      else
        sr_tmr_reg <= sr_tmr_reg - 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      mr_seen_reg <= 2'h0;
      lost_reg    <= 1'b0;
      ign_reg     <= 1'b0;
    end else begin
      ign_reg <= ign_next;
      if (deep_in) begin
        mr_seen_reg <= 2'h0;
        lost_reg    <= 1'b1;
      end else begin
        if (c_mrs)
          mr_seen_reg[link.ba == MR_EXT_BANK] <= 1'b1;
        if ((mode_reg == MD_UNINIT) & (mode_next == MD_RUN))
          lost_reg <= 1'b0;
      end
    end
  end

  assign o_mode          = mode_reg;
  assign o_bank_open     = open_vec;
  assign o_refresh_row   = row_reg;
  assign o_refresh_pulse = ref_pulse_reg;
  assign o_pre_ignored   = ign_reg;
  assign o_data_lost     = lost_reg;
endmodule

// *** tb/dpr_link_props.sv ***
// Link pin checks between controller and device ends.
// Assumes the link signals come in as plain inputs.
module dpr_link_props
  import dpr_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  input  wire logic ck_run,
  input  wire logic cke,
  input  wire logic ras_n,
  input  wire logic cas_n,
  input  wire logic we_n
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [2:0] cmd = {ras_n, cas_n, we_n};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  a_act_pre_gap: assert property (
    cke && (cmd == CMD_ACT || cmd == CMD_PRE) |=> cmd == CMD_NOP)
    else $error("no gap after activate or precharge");
  a_ref_gap: assert property (
    cke && $past(cke) && cmd == CMD_REF |=> (cmd == CMD_NOP) [*7])
    else $error("refresh cycle time broken");
  a_sref_clk: assert property (
    $fell(cke) && cmd == CMD_REF |=> !ck_run)
    else $error("clock not stopped in self refresh");
  a_sref_dwell: assert property (
    $fell(cke) && cmd == CMD_REF |-> (!cke) [*8])
    else $error("self refresh left too early");
  a_exit_clk: assert property ($rose(cke) |-> $past(ck_run))
    else $error("clock-enable raised with clock stopped");
  a_pdn_min: assert property ($fell(cke) |-> (!cke) [*2])
    else $error("clock-enable low too short");
  a_exit_nop: assert property (
    $rose(cke) |-> cmd == CMD_NOP ##1 cmd == CMD_NOP)
    else $error("command too soon after exit");
  a_restart_nop: assert property ($rose(ck_run) |-> cmd == CMD_NOP)
    else $error("no nop after clock restart");
  cover property ($fell(cke) && cmd == CMD_REF);
  cover property ($fell(cke) && cmd == CMD_BST);
  cover property ($fell(ck_run) && cke);
endmodule

// *** tb/tb_dpr_precharge_refresh_power_states.sv ***
// Bench joining both ends over the link; self-checking scenarios.
// Assumes one 100 MHz clock and a synchronous active-high reset.
module tb_dpr_precharge_refresh_power_states;
  timeunit 1ns;
  timeprecision 1ps;
  import dpr_pkg::*;
  logic        clk = 0, rst = 1, valid = 0, apre = 0, seen = 0;
  logic        ack, rej, pign, lost, rpulse;
  dpr_op_t     op = OP_ACT;
  logic [1:0]  bank = 2'h0;
  dpr_mode_t   cmode, dmode;
  logic [3:0]  bopen, pend;
  logic [11:0] rrow, r0;
  logic [7:0]  npulse, p0;
  int          fails = 0, check_count = 0, cyc = 0;
  dpr_link_if link ();
  dpr_mem_ctrl #(.DEEP_WAIT_CYC(50), .REFI_CYC(3000)) u_dpr_mem_ctrl (
    .i_core_clk(clk), .i_sys_rst(rst), .link(link.ctrl),
    .i_cmd_valid(valid), .i_cmd_op(op), .i_cmd_bank(bank),
    .i_cmd_addr(13'h0), .i_cmd_auto_pre(apre), .o_cmd_ack(ack),
    .o_cmd_reject(rej), .o_dev_mode(cmode), .o_ref_pending(pend));
  dpr_mem_dev u_dpr_mem_dev (.i_core_clk(clk), .i_sys_rst(rst),
    .link(link.dev), .o_mode(dmode), .o_bank_open(bopen),
    .o_refresh_row(rrow), .o_refresh_pulse(rpulse), .o_pre_ignored(pign),
    .o_data_lost(lost));
  dpr_link_props u_props (.i_core_clk(clk), .i_sys_rst(rst),
    .ck_run(link.ck_run), .cke(link.cke), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    seen <= !rst && (seen | pign);
    npulse <= rst ? 8'h0 : npulse + 8'(rpulse);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic req(input dpr_op_t o, input logic [1:0] b,
                     input logic ap, input logic ok);
    int n;
    @(negedge clk);
    valid = 1;
    op = o;
    bank = b;
    apre = ap;
    n = 0;
    while (!(ack || rej) && n < 400) begin
      @(negedge clk);
      n++;
    end
    valid = 0;
    chk({ack, rej}, {ok, !ok});
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_bank();
    req(OP_ACT, 2'h1, 0, 1);
    req(OP_RD, 2'h2, 0, 0);
    req(OP_DEEP_PDN, 2'h0, 0, 0);
    chk(bopen, 4'h2);
    req(OP_WR, 2'h1, 1, 1);
    wt(8);
    chk(bopen, 4'h0);
    req(OP_PRE, 2'h1, 0, 1);
    wt(3);
    chk(seen, 1'b1);
    req(OP_ACT, 2'h0, 0, 1);
    req(OP_ACT, 2'h3, 0, 1);
    wt(3);
    chk(bopen, 4'h9);
    req(OP_PRE_ALL, 2'h1, 0, 1);
    wt(3);
    chk(bopen, 4'h0);
    r0 = rrow;
    p0 = npulse;
    req(OP_REF, 2'h0, 0, 1);
    wt(3);
    chk(rrow, r0 + 12'h1);
    chk(npulse, p0 + 8'h1);
  endtask
  task automatic t_pdn(input logic act, input dpr_mode_t m);
    if (act) req(OP_ACT, 2'h2, 0, 1);
    req(OP_PDN, 2'h0, 0, 1);
    wt(3);
    chk(dmode, m);
    req(OP_ACT, 2'h0, 0, 0);
    req(OP_WAKE, 2'h0, 0, 1);
    wt(3);
    chk(dmode, MD_RUN);
    if (act) req(OP_PRE, 2'h2, 0, 1);
  endtask
  task automatic t_lowpow();
    req(OP_SREF, 2'h0, 0, 1);
    wt(3);
    chk(dmode, MD_SREF);
    chk(link.ck_run, 1'b0);
    wt(20);
    r0 = rrow;
    req(OP_WAKE, 2'h0, 0, 1);
    chk(pend, 4'h1);
    wt(40);
    chk(dmode, MD_RUN);
    chk(rrow, r0 + 12'h1);
    req(OP_DEEP_PDN, 2'h0, 0, 1);
    wt(3);
    chk(dmode, MD_DEEP_PDN);
    chk(lost, 1'b1);
    req(OP_REF, 2'h0, 0, 0);
    req(OP_WAKE, 2'h0, 0, 1);
    wt(40);
    chk(cmode, MD_UNINIT);
    wt(80);
    chk(cmode, MD_RUN);
    chk(lost, 1'b0);
    req(OP_CKSTOP, 2'h0, 0, 1);
    wt(2);
    chk(link.ck_run, 1'b0);
    req(OP_WAKE, 2'h0, 0, 1);
    wt(2);
    chk(link.ck_run, 1'b1);
  endtask
  task automatic t_refi();
    r0 = rrow;
    wt(3000);
    chk(rrow, r0 + 12'h1);
    chk(pend, 4'h0);
  endtask
  task automatic print_verdict();
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    wt(8);
    rst = 0;
    t_bank();
    t_pdn(0, MD_PRE_PDN);
    t_pdn(1, MD_ACT_PDN);
    t_lowpow();
    t_refi();
    print_verdict();
  end
endmodule
